/* File: sop_pkg.sv */
// constants, register map and types of the sequence overvoltage protection block
package sop_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word per register)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DELTA_FACTOR = 8'h04;
    localparam logic [7:0] OFS_THR_BASE = 8'h08;
    localparam logic [7:0] OFS_DELAY_BASE = 8'h28;
    localparam logic [7:0] OFS_RATIO_BASE = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h58;
    localparam logic [7:0] OFS_PHASE = 8'h5C;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_U4_LSB = 8;
    localparam int CTRL_ALL_CT_VT = 10;
    localparam int CTRL_RESTRAINT = 11;
    localparam int CTRL_WIDTH = 12;
    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STAT_PICKUP_LSB = 0;
    localparam int STAT_EXPIRED_LSB = 8;
    localparam int STAT_TRIP_LSB = 16;
    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int NUM_FUNC = 4;
    localparam int NUM_STAGE = 8;
    localparam int MAG_W = 20;
    localparam int DLY_W = 16;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 12'h0_55;
    localparam logic [15:0] DELTA_FACTOR_RESET = 16'h01BB; // 1.73 in 8 fraction bits
    localparam logic [MAG_W-1:0] THR_RESET = 20'h0_4000;
    localparam logic [DLY_W-1:0] DELAY_RESET = 16'h0064; // milliseconds
    localparam logic [7:0] RATIO_RESET = 8'h7A; // 0.95 in 7 fraction bits
    localparam logic signed [17:0] SQRT3_HALF_Q15 = 18'sh0_6EDA;
    localparam logic [17:0] THIRD_Q16 = 18'h0_5555;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_TICK_NS = 1000000;
    localparam int TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
    localparam int RESTRAINT_PERIODS = 3;
    localparam int SAMPLES_PER_PERIOD = 20;
    localparam int RESTRAINT_SAMPLES = RESTRAINT_PERIODS * SAMPLES_PER_PERIOD;
    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SOP_MODE_OFF = 2'b00,
        SOP_MODE_ON = 2'b01,
        SOP_MODE_ALARM = 2'b10
    } sop_mode_type;
    typedef enum logic [1:0] {
        SOP_U4_NONE = 2'b00,
        SOP_U4_DELTA = 2'b01,
        SOP_U4_SINGLE = 2'b10
    } sop_u4_type;
endpackage

/* File: sop_top.sv */
// sequence overvoltage protection: four measuring paths, eight stages, avalon register slave
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module sop_top #(
    parameter int TICK_CYCLES = sop_pkg::TICK_CYCLES,
    parameter int RESTRAINT_SAMPLES = sop_pkg::RESTRAINT_SAMPLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sample_valid,
    input wire logic signed [15:0] l1_re,
    input wire logic signed [15:0] l1_im,
    input wire logic signed [15:0] l2_re,
    input wire logic signed [15:0] l2_im,
    input wire logic signed [15:0] l3_re,
    input wire logic signed [15:0] l3_im,
    input wire logic signed [15:0] fourth_voltage_input_re,
    input wire logic signed [15:0] fourth_voltage_input_im,
    input wire logic line_line_ov_block_in,
    input wire logic pos_seq_ov_block_in,
    input wire logic neg_seq_ov_block_in,
    input wire logic zero_seq_ov_block_in,
    input wire logic vt_breaker_trip_in,
    input wire logic fuse_fail_asym_in,
    input wire logic single_pole_dead_in,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] stage_pickup,
    output logic [7:0] stage_expired,
    output logic [3:0] func_trip,
    output logic [2:0] line_line_phase_low,
    output logic [2:0] line_line_phase_high
);
    localparam int NS = sop_pkg::NUM_STAGE;
    localparam int MW = sop_pkg::MAG_W;
    localparam int DW = sop_pkg::DLY_W;

    typedef struct packed {
        logic [6:0] pin_q1;
        logic [6:0] pin_q2;
        logic ack;
        logic [31:0] rdata;
        logic [sop_pkg::CTRL_WIDTH-1:0] ctrl;
        logic [15:0] delta_factor;
        logic [NS-1:0][MW-1:0] thr;
        logic [NS-1:0][DW-1:0] delay;
        logic [3:0][7:0] ratio;
        logic [NS-1:0][2:0] held;
        logic [NS-1:0][DW-1:0] timer;
        logic [1:0][7:0] confirm;
        logic [31:0] tick_cnt;
        logic tick;
        logic [NS-1:0] pickup;
        logic [NS-1:0] expired;
        logic [3:0] trip;
    } sop_state_type;

    sop_state_type st;
    sop_state_type next_st;
    logic rst_q1;
    logic rst_q2;

    // ------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------
    // rotate a phasor by +120 (k=0) or +240 (k=1) degrees, result 20-bit re and im
    function automatic logic signed [39:0] sop_rot(input logic signed [19:0] x, input logic signed [19:0] y,
                                                   input logic k);
        logic signed [37:0] sx;
        logic signed [37:0] sy;
        logic signed [19:0] re;
        logic signed [19:0] im;
        sx = x * sop_pkg::SQRT3_HALF_Q15;
        sy = y * sop_pkg::SQRT3_HALF_Q15;
        if (k == 1'b0) begin
            re = (-(x >>> 1)) - 20'(sy >>> 15);
            im = 20'(sx >>> 15) - (y >>> 1);
        end else begin
            re = (-(x >>> 1)) + 20'(sy >>> 15);
            im = (-20'(sx >>> 15)) - (y >>> 1);
        end
        return {re, im};
    endfunction

    // magnitude estimate max + 3/8 min; within a few percent, avoids a square root
    function automatic logic [MW-1:0] sop_mag(input logic signed [19:0] re, input logic signed [19:0] im);
        logic [19:0] a;
        logic [19:0] b;
        logic [19:0] hi;
        logic [19:0] lo;
        a = re[19] ? 20'(-re) : 20'(re);
        b = im[19] ? 20'(-im) : 20'(im);
        hi = (a > b) ? a : b;
        lo = (a > b) ? b : a;
        return hi + (lo >> 2) + (lo >> 3);
    endfunction

    // scale by one third
    function automatic logic signed [19:0] sop_third(input logic signed [19:0] v);
        logic signed [38:0] p;
        p = v * $signed({1'b0, sop_pkg::THIRD_Q16});
        return 20'(p >>> 16);
    endfunction

    // ------------------------------------------------------------
    // measured quantities
    // ------------------------------------------------------------
    logic signed [19:0] x1, y1, x2, y2, x3, y3, x4, y4;
    logic signed [39:0] p2, p3, n2, n3;
    logic signed [19:0] zr, zi;
    logic signed [35:0] dr, di;
    logic [NS-1:0][2:0][MW-1:0] meas;
    logic [3:0] func_block;

    assign x1 = 20'(l1_re);
    assign y1 = 20'(l1_im);
    assign x2 = 20'(l2_re);
    assign y2 = 20'(l2_im);
    assign x3 = 20'(l3_re);
    assign y3 = 20'(l3_im);
    assign x4 = 20'(fourth_voltage_input_re);
    assign y4 = 20'(fourth_voltage_input_im);
    assign p2 = sop_rot(x2, y2, 1'b0);
    assign p3 = sop_rot(x3, y3, 1'b1);
    assign n2 = sop_rot(x2, y2, 1'b1);
    assign n3 = sop_rot(x3, y3, 1'b0);
    assign dr = x4 * $signed({1'b0, st.delta_factor});
    assign di = y4 * $signed({1'b0, st.delta_factor});

    // zero sequence source follows the fourth input assignment
    always_comb begin
        case (sop_pkg::sop_u4_type'(st.ctrl[sop_pkg::CTRL_U4_LSB +: 2]))
            sop_pkg::SOP_U4_DELTA: begin
                zr = 20'(dr >>> 8);
                zi = 20'(di >>> 8);
            end
            sop_pkg::SOP_U4_SINGLE: begin
                zr = x4;
                zi = y4;
            end
            default: begin
                zr = x1 + x2 + x3;
                zi = y1 + y2 + y3;
            end
        endcase
    end

    // stage inputs: line-line uses three quantities, the other paths use one
    always_comb begin
        meas = '0;
        for (int s = 0; s < 2; s++) begin
            meas[s][0] = sop_mag(x1 - x2, y1 - y2);
            meas[s][1] = sop_mag(x2 - x3, y2 - y3);
            meas[s][2] = sop_mag(x3 - x1, y3 - y1);
            meas[2+s][0] = sop_mag(sop_third(x1 + p2[39:20] + p3[39:20]),
                                   sop_third(y1 + p2[19:0] + p3[19:0]));
            meas[4+s][0] = sop_mag(sop_third(x1 + n2[39:20] + n3[39:20]),
                                   sop_third(y1 + n2[19:0] + n3[19:0]));
            meas[6+s][0] = sop_mag(zr, zi);
        end
    end

    // ------------------------------------------------------------
    // blocking per function (pins after synchronisers)
    // ------------------------------------------------------------
    logic dead_blk;
    logic auto_blk;
    assign dead_blk = st.pin_q2[6] & st.ctrl[sop_pkg::CTRL_ALL_CT_VT];
    assign auto_blk = st.pin_q2[5] | st.pin_q2[4] | dead_blk;
    always_comb begin
        func_block[0] = st.pin_q2[0];
        func_block[1] = st.pin_q2[1];
        func_block[2] = st.pin_q2[2] | auto_blk;
        if (st.ctrl[sop_pkg::CTRL_U4_LSB +: 2] == sop_pkg::SOP_U4_SINGLE) begin
            func_block[3] = st.pin_q2[3];
        end else begin
            func_block[3] = st.pin_q2[3] | auto_blk;
        end
    end

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic req;
    logic [31:0] rd_val;
    logic [31:0] wmask;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~st.ack; // one wait cycle per access
    assign avs_readdata = st.rdata;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                    {8{avs_byteenable[0]}}};

    // readback mux; unmapped offsets read zero
    always_comb begin
        rd_val = '0;
        if (avs_address == sop_pkg::OFS_CTRL) begin
            rd_val = 32'(st.ctrl);
        end else if (avs_address == sop_pkg::OFS_DELTA_FACTOR) begin
            rd_val = 32'(st.delta_factor);
        end else if (avs_address == sop_pkg::OFS_STATUS) begin
            rd_val = {8'h00, 4'h0, st.trip, st.expired, st.pickup};
        end else if (avs_address == sop_pkg::OFS_PHASE) begin
            rd_val = {26'h000_0000, st.held[1], st.held[0]};
        end
        for (int i = 0; i < NS; i++) begin
            if (avs_address == sop_pkg::OFS_THR_BASE + 8'(4 * i)) begin
                rd_val = 32'(st.thr[i]);
            end
            if (avs_address == sop_pkg::OFS_DELAY_BASE + 8'(4 * i)) begin
                rd_val = 32'(st.delay[i]);
            end
        end
        for (int f = 0; f < 4; f++) begin
            if (avs_address == sop_pkg::OFS_RATIO_BASE + 8'(4 * f)) begin
                rd_val = 32'(st.ratio[f]);
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [2:0] raw;
        logic [27:0] drop;
        logic [1:0] fmode;
        logic act;
        int f;
        wv = '0;
        raw = '0;
        drop = '0;
        fmode = '0;
        act = 1'b0;
        f = 0;
        next_st = st;
        next_st.pin_q1 = {single_pole_dead_in, fuse_fail_asym_in, vt_breaker_trip_in, zero_seq_ov_block_in,
                          neg_seq_ov_block_in, pos_seq_ov_block_in, line_line_ov_block_in};
        next_st.pin_q2 = st.pin_q1;
        // bus: data captured on the waiting cycle, write applied at the answering edge
        next_st.ack = req & ~st.ack;
        if (req & ~st.ack) begin
            next_st.rdata = avs_read ? rd_val : 32'h0000_0000;
        end
        if (avs_write & st.ack) begin
            wv = (rd_val & ~wmask) | (avs_writedata & wmask);
            if (avs_address == sop_pkg::OFS_CTRL) begin
                next_st.ctrl = wv[sop_pkg::CTRL_WIDTH-1:0];
            end
            if (avs_address == sop_pkg::OFS_DELTA_FACTOR) begin
                next_st.delta_factor = wv[15:0];
            end
            for (int i = 0; i < NS; i++) begin
                if (avs_address == sop_pkg::OFS_THR_BASE + 8'(4 * i)) begin
                    next_st.thr[i] = wv[MW-1:0];
                end
                if (avs_address == sop_pkg::OFS_DELAY_BASE + 8'(4 * i)) begin
                    next_st.delay[i] = wv[DW-1:0];
                end
            end
            for (int k = 0; k < 4; k++) begin
                if (avs_address == sop_pkg::OFS_RATIO_BASE + 8'(4 * k)) begin
                    next_st.ratio[k] = wv[7:0];
                end
            end
        end
        // millisecond tick for the stage delays
        next_st.tick = 1'b0;
        if (st.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 32'd1;
        end
        // one loop over all eight stages
        for (int s = 0; s < NS; s++) begin
            f = s / 2;
            fmode = st.ctrl[sop_pkg::CTRL_MODE_LSB + 2*f +: 2];
            act = (fmode != sop_pkg::SOP_MODE_OFF) & ~func_block[f];
            if (sample_valid) begin
                for (int q = 0; q < 3; q++) begin
                    drop = 28'(({8'h00, st.thr[s]} * {20'h0_0000, st.ratio[f]}) >> 7);
                    if (!act) begin
                        raw[q] = 1'b0;
                    end else if (meas[s][q] > st.thr[s]) begin
                        raw[q] = 1'b1;
                    end else if (28'(meas[s][q]) < drop) begin
                        raw[q] = 1'b0;
                    end else begin
                        raw[q] = st.held[s][q]; // hysteresis band keeps the state
                    end
                end
                next_st.held[s] = raw;
                next_st.pickup[s] = |raw;
                // zero sequence restraint: condition must persist over repeated samples
                if (s >= 6 && st.ctrl[sop_pkg::CTRL_RESTRAINT]) begin
                    if (!(|raw)) begin
                        next_st.confirm[s-6] = '0;
                        next_st.pickup[s] = 1'b0;
                    end else if (32'(st.confirm[s-6]) < 32'(RESTRAINT_SAMPLES)) begin
                        next_st.confirm[s-6] = st.confirm[s-6] + 8'd1;
                        next_st.pickup[s] = 1'b0;
                    end
                end
            end
            // one timer per stage on the shared tick; restarts whenever pickup falls before expiry
            if (!next_st.pickup[s]) begin
                next_st.timer[s] = '0;
                next_st.expired[s] = 1'b0;
            end else if (st.timer[s] >= st.delay[s]) begin
                next_st.expired[s] = 1'b1;
            end else if (st.tick) begin
                next_st.timer[s] = st.timer[s] + 16'd1;
            end
        end
        // trip only in full mode; alarm mode keeps the indications
        for (int k = 0; k < 4; k++) begin
            next_st.trip[k] = (|next_st.expired[2*k +: 2]) &
                              (st.ctrl[sop_pkg::CTRL_MODE_LSB + 2*k +: 2] == sop_pkg::SOP_MODE_ON);
        end
    end

    // ------------------------------------------------------------
    // reset release and state register
    // ------------------------------------------------------------
    // reset is released through two stages so all state leaves reset on one edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    // whole block state
    always_ff @(posedge clk_sys or negedge rst_q2) begin
        if (!rst_q2) begin
            st <= '0;
            st.ctrl <= sop_pkg::CTRL_RESET;
            st.delta_factor <= sop_pkg::DELTA_FACTOR_RESET;
            st.thr <= {NS{sop_pkg::THR_RESET}};
            st.delay <= {NS{sop_pkg::DELAY_RESET}};
            st.ratio <= {4{sop_pkg::RATIO_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign stage_pickup = st.pickup;
    assign stage_expired = st.expired;
    assign func_trip = st.trip;
    assign line_line_phase_low = st.held[0];
    assign line_line_phase_high = st.held[1];
endmodule

/* File: sop_top_assertions.sv */
// assertion checker watching the sequence overvoltage block ports
`timescale 1ns/1ps
module sop_top_assertions #(
    parameter int TICK_CYCLES = 4,
    parameter int RESTRAINT_SAMPLES = 3
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sample_valid,
    input wire logic line_line_ov_block_in,
    input wire logic pos_seq_ov_block_in,
    input wire logic neg_seq_ov_block_in,
    input wire logic zero_seq_ov_block_in,
    input wire logic vt_breaker_trip_in,
    input wire logic fuse_fail_asym_in,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [7:0] stage_pickup,
    input wire logic [7:0] stage_expired,
    input wire logic [3:0] func_trip,
    input wire logic [2:0] line_line_phase_low,
    input wire logic [2:0] line_line_phase_high
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // block pins pass a two-flop synchroniser, so four held cycles plus a sample must clear
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_bus_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait state");
    property p_ll_block; line_line_ov_block_in [*4] ##0 sample_valid |=> stage_pickup[1:0] == 2'b00; endproperty
    a_ll_block: assert property (p_ll_block) else $error("line-line pickup while blocked");
    property p_pos_block; pos_seq_ov_block_in [*4] ##0 sample_valid |=> stage_pickup[3:2] == 2'b00; endproperty
    a_pos_block: assert property (p_pos_block) else $error("positive pickup while blocked");
    property p_neg_block;
        (neg_seq_ov_block_in || vt_breaker_trip_in || fuse_fail_asym_in) [*4] ##0 sample_valid
            |=> stage_pickup[5:4] == 2'b00;
    endproperty
    a_neg_block: assert property (p_neg_block) else $error("negative pickup while blocked");
    property p_zero_block; zero_seq_ov_block_in [*4] ##0 sample_valid |=> stage_pickup[7:6] == 2'b00; endproperty
    a_zero_block: assert property (p_zero_block) else $error("zero pickup while blocked");
    property p_phase;
        ((|line_line_phase_low) == stage_pickup[0]) && ((|line_line_phase_high) == stage_pickup[1]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase flags disagree with pickup");
    property p_expired_pickup; (stage_expired & ~(stage_pickup & $past(stage_pickup))) == 8'h00; endproperty
    a_expired_pickup: assert property (p_expired_pickup) else $error("expiry without held pickup");
    property p_trip_expired;
        (func_trip & ~{|stage_expired[7:6], |stage_expired[5:4], |stage_expired[3:2], |stage_expired[1:0]}) == 4'h0;
    endproperty
    a_trip_expired: assert property (p_trip_expired) else $error("trip without expiry");
    property p_pickup_on_sample; $changed(stage_pickup) |-> $past(sample_valid); endproperty
    a_pickup_on_sample: assert property (p_pickup_on_sample) else $error("pickup moved off sample");
endmodule
bind sop_top sop_top_assertions #(.TICK_CYCLES(TICK_CYCLES), .RESTRAINT_SAMPLES(RESTRAINT_SAMPLES)) sop_chk_i (
    .clk_sys, .rst_b, .sample_valid, .line_line_ov_block_in, .pos_seq_ov_block_in, .neg_seq_ov_block_in,
    .zero_seq_ov_block_in, .vt_breaker_trip_in, .fuse_fail_asym_in, .avs_read, .avs_write, .avs_waitrequest,
    .stage_pickup, .stage_expired, .func_trip, .line_line_phase_low, .line_line_phase_high);

/* File: sop_vt_model.sv */
// voltage transformer and substation binary input model
`timescale 1ns/1ps
module sop_vt_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] kind,
    input wire logic signed [15:0] amp,
    input wire logic [7:0] pins,
    output logic sample_valid,
    output logic [3:0][15:0] ph_re,
    output logic [3:0][15:0] ph_im,
    output logic [6:0] pin_out
);
    // ------------------------------------------------------------
    // phasor source
    // ------------------------------------------------------------
    logic signed [15:0] half;
    logic signed [15:0] tip;
    // rotated phases: real part -amp/2, imaginary amp times sin of 120 degrees
    assign half = -(amp >>> 1);
    assign tip = 16'((32'(amp) * 28378) >>> 15);
    // strobe every second edge so the block sees gaps between sample sets
    always @(posedge clk_sys) begin
        sample_valid <= rst_b & ~sample_valid;
        ph_im <= '0;
        case (kind)
            4'h0: begin
                ph_re <= {16'h0000, half, half, amp};
                ph_im <= {16'h0000, tip, -tip, 16'h0000};
            end
            4'h1: begin
                ph_re <= {16'h0000, half, half, amp};
                ph_im <= {16'h0000, -tip, tip, 16'h0000};
            end
            4'h2: ph_re <= {16'h0000, amp, amp, amp};
            default: ph_re <= {amp, 16'h0000, 16'h0000, 16'h0000};
        endcase
        // an outside single-pole trip also raises the negative and zero block pins
        pin_out <= {pins[6:4], pins[3] | pins[7], pins[2] | pins[7], pins[1:0]};
    end
endmodule

/* File: testbench.sv */
// self-checking bench for the sequence overvoltage block
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals, instances and tasks
    // ------------------------------------------------------------
    localparam int TK = 4;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] stage_pickup;
    logic [7:0] stage_expired;
    logic [3:0] func_trip;
    logic [2:0] ll_lo;
    logic [2:0] ll_hi;
    logic [3:0] kind = 4'h2;
    logic [15:0] amp = 16'h0000;
    logic [7:0] pins = 8'h00;
    logic sample_valid;
    logic [3:0][15:0] ph_re;
    logic [3:0][15:0] ph_im;
    logic [6:0] pin_out;
    logic wait_seen;
    logic [31:0] rd_seen;
    logic [31:0] rdata;
    int bad_count = 0;
    int check_count = 0;
    int n;
    // rows: control, source kind, amplitude, pins {ext,dead,fuse,vt,zero,neg,pos,ll}, pickup
    logic [47:0] rows [23] = '{48'h0550_7530_000F, 48'h0550_7530_010C, 48'h0550_7530_0203,
        48'h0510_7530_0003, 48'h0551_7530_0033, 48'h0551_7530_0403, 48'h0551_7530_1003,
        48'h0551_7530_2003, 48'h0551_7530_4033, 48'h4551_7530_4003, 48'h0551_7530_8003,
        48'h0552_2328_00C0, 48'h0552_2328_0800, 48'h0552_2328_1000, 48'h4552_2328_4000,
        48'h0552_2328_40C0, 48'h1553_2710_0040, 48'h6553_7530_70C0, 48'h2553_7530_0800,
        48'h0550_4268_0007, 48'h0550_3E80_0007, 48'h0550_3A98_0003, 48'h0552_0000_0000};
    logic [39:0] regs [7] = '{40'h00_0000_0055, 40'h04_0000_01BB, 40'h08_0000_4000, 40'h28_0000_0064,
        40'h48_0000_007A, 40'h80_0000_0000, 40'h58_0000_0000};
    always #25 clk_sys = ~clk_sys;
    // waitrequest and read data only move after a rising edge, so the falling edge sees the edge value
    always @(negedge clk_sys) begin
        wait_seen <= avs_waitrequest;
        rd_seen <= avs_readdata;
    end
    sop_vt_model sop_vt_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .kind(kind), .amp(amp), .pins(pins),
        .sample_valid(sample_valid), .ph_re(ph_re), .ph_im(ph_im), .pin_out(pin_out));
    sop_top #(.TICK_CYCLES(TK), .RESTRAINT_SAMPLES(3)) sop_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .sample_valid(sample_valid), .l1_re(ph_re[0]), .l1_im(ph_im[0]), .l2_re(ph_re[1]), .l2_im(ph_im[1]),
        .l3_re(ph_re[2]), .l3_im(ph_im[2]), .fourth_voltage_input_re(ph_re[3]), .fourth_voltage_input_im(ph_im[3]),
        .line_line_ov_block_in(pin_out[0]), .pos_seq_ov_block_in(pin_out[1]), .neg_seq_ov_block_in(pin_out[2]),
        .zero_seq_ov_block_in(pin_out[3]), .vt_breaker_trip_in(pin_out[4]), .fuse_fail_asym_in(pin_out[5]),
        .single_pole_dead_in(pin_out[6]), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stage_pickup(stage_pickup), .stage_expired(stage_expired),
        .func_trip(func_trip), .line_line_phase_low(ll_lo), .line_line_phase_high(ll_hi));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one avalon transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wait_seen !== 1'b0 && k < 40);
        if (k == 40) begin
            bad_count++;
            finish_test;
        end
        rdata = rd_seen;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // watchdog so a stuck handshake still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        finish_test;
    end
    // main sequence: registers, row table, then timer, alarm and restraint cases
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        settle(4);
        chk(32'({stage_pickup, stage_expired, func_trip, ll_lo, ll_hi}), 32'h0000_0000);
        bus(1'b1, 8'h80, 32'hFFFF_FFFF);
        bus(1'b1, 8'h58, 32'hFFFF_FFFF);
        foreach (regs[i]) begin
            bus(1'b0, regs[i][39:32], 32'h0000_0000);
            chk(rdata, regs[i][31:0]);
        end
        for (int i = 1; i < 8; i += 2) bus(1'b1, 8'h08 + 8'(4 * i), 32'h0000_5DC0);
        foreach (rows[i]) begin
            bus(1'b1, 8'h00, 32'(rows[i][47:36]));
            kind <= rows[i][35:32];
            amp <= rows[i][31:16];
            pins <= rows[i][15:8];
            settle(14);
            chk(32'(stage_pickup), 32'(rows[i][7:0]));
            chk(32'({ll_hi, ll_lo}), 32'({{3{rows[i][1]}}, {3{rows[i][0]}}}));
        end
        bus(1'b1, 8'h30, 32'h0000_0003);
        kind <= 4'h0;
        amp <= 16'h4268;
        for (n = 0; stage_pickup[2] !== 1'b1 && n < 40; n++) @(negedge clk_sys);
        for (n = 0; stage_expired[2] !== 1'b1 && n < 40; n++) @(negedge clk_sys);
        chk(32'(n >= 2 * TK && n <= 3 * TK + 2), 32'h0000_0001);
        chk(32'(func_trip), 32'h0000_0002);
        bus(1'b1, 8'h00, 32'h0000_0059);
        settle(2);
        chk(32'({func_trip, stage_expired[2]}), 32'h0000_0001);
        @(posedge clk_sys);
        amp <= 16'h0000;
        settle(6);
        chk(32'({stage_pickup, stage_expired}), 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0855);
        kind <= 4'h2;
        amp <= 16'h2328;
        settle(3);
        chk(32'(stage_pickup[7:6]), 32'h0000_0000);
        settle(16);
        chk(32'(stage_pickup[7:6]), 32'h0000_0003);
        finish_test;
    end
endmodule
